// ==== rtl/tws_core.v ====
// two-wire hardware slave with software master mode, on the core sfr bus
`timescale 1ns/1ps
`include "tws_defines.vh"

module tws_core #(
   parameter [3:0] FILT_CYCLES = `TWS_FILT_CYCLES
) (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   input wire spi_enable_bit,
   input wire spi_relocate,
   input wire irq_enable_prio2,
   input wire global_irq_enable,
   output reg irq_req,
   output reg [15:0] irq_vector,
   input wire serial_data_pin_in,
   output reg serial_data_pin_out,
   output reg serial_data_pin_oe,
   input wire serial_clock_pin_in,
   output reg serial_clock_pin_out,
   output reg serial_clock_pin_oe
);

   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_RXB = 7'h02;
   localparam [6:0] S_ACK = 7'h04;
   localparam [6:0] S_STR = 7'h08;
   localparam [6:0] S_TXB = 7'h10;
   localparam [6:0] S_TACK = 7'h20;
   localparam [6:0] S_HALT = 7'h40;

   function addr_hit;
      input [7:0] first_byte;
      input [7:0] own_addr;
      begin
         addr_hit = (first_byte[7:1] == own_addr[6:0]);
      end
   endfunction

   // pin synchronisers and glitch filters, index 0 data, 1 clock
   wire [1:0] raw_pin;
   reg [1:0] meta_reg;
   reg [1:0] sync_reg;
   reg [1:0] filt_reg;
   reg [1:0] filt_prev_reg;
   assign raw_pin = {serial_clock_pin_in, serial_data_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
         reg [3:0] stable_cnt_reg;
         always @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               meta_reg[gi] <= 1'b1;
               sync_reg[gi] <= 1'b1;
               filt_reg[gi] <= 1'b1;
               filt_prev_reg[gi] <= 1'b1;
               stable_cnt_reg <= 4'h0;
            end else begin
               meta_reg[gi] <= raw_pin[gi];
               sync_reg[gi] <= meta_reg[gi];
               filt_prev_reg[gi] <= filt_reg[gi];
               // new level must persist the whole window to be accepted
               if (sync_reg[gi] != filt_reg[gi]) begin
                  if (stable_cnt_reg == FILT_CYCLES - 4'h1) begin
                     filt_reg[gi] <= sync_reg[gi];
                     stable_cnt_reg <= 4'h0;
                  end else begin
                     stable_cnt_reg <= stable_cnt_reg + 4'h1;
                  end
               end else begin
                  stable_cnt_reg <= 4'h0;
               end
            end
         end
      end
   endgenerate

   wire sda_f = filt_reg[0];
   wire scl_f = filt_reg[1];
   wire scl_rise = scl_f & ~filt_prev_reg[1];
   wire scl_fall = ~scl_f & filt_prev_reg[1];
   wire start_det = scl_f & filt_prev_reg[1] & ~sda_f & filt_prev_reg[0];
   wire stop_det = scl_f & filt_prev_reg[1] & sda_f & ~filt_prev_reg[0];

   // software registers
   reg [7:0] slave_address_a_reg;
   reg [7:0] slave_address_b_reg;
   reg [7:0] slave_address_c_reg;
   reg [7:0] slave_address_d_reg;
   reg master_select_reg;
   reg sw_data_out_reg;
   reg sw_data_drive_en_reg;
   reg sw_clock_out_reg;
   reg sw_data_in_reg;
   reg stop_irq_en_reg;
   reg iface_soft_reset_reg;

   // slave engine
   reg [6:0] state_reg;
   reg [7:0] shift_reg;
   reg [2:0] bit_cnt_reg;
   reg got8_reg;
   reg addr_phase_reg;
   reg rep_start_reg;
   reg sda_low_reg;
   reg xfer_direction_reg;
   reg byte_done_flag_reg;
   reg [1:0] irq_cause_reg;
   reg accessed_reg;
   reg [7:0] serial_byte_data_reg;

   wire iface_en = ~spi_enable_bit | spi_relocate;
   wire con_wr = sfr_wr & (sfr_addr == `TWS_ADDR_CON);
   wire data_access = (sfr_wr | sfr_rd) & (sfr_addr == `TWS_ADDR_DAT);
   wire slave_hold = iface_soft_reset_reg | master_select_reg |
                     ~iface_en;
   wire any_hit = addr_hit(shift_reg, slave_address_a_reg) |
                  addr_hit(shift_reg, slave_address_b_reg) |
                  addr_hit(shift_reg, slave_address_c_reg) |
                  addr_hit(shift_reg, slave_address_d_reg);
   wire byte_set = (state_reg == S_ACK & scl_fall) |
                   (state_reg == S_TACK & scl_fall & got8_reg);
   // halting only counts once an exchange is under way; idle setup is free
   wire halt_now = data_access & accessed_reg & ~byte_set &
                   (state_reg != S_IDLE) & ~slave_hold;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         slave_address_a_reg <= `TWS_RST_ADD_A;
         slave_address_b_reg <= `TWS_RST_ADD_X;
         slave_address_c_reg <= `TWS_RST_ADD_X;
         slave_address_d_reg <= `TWS_RST_ADD_X;
         master_select_reg <= 1'b0;
         sw_data_out_reg <= 1'b0;
         sw_data_drive_en_reg <= 1'b0;
         sw_clock_out_reg <= 1'b0;
         sw_data_in_reg <= 1'b0;
         stop_irq_en_reg <= 1'b0;
         iface_soft_reset_reg <= 1'b0;
      end else begin
         if (sfr_wr) begin
            case (sfr_addr)
               `TWS_ADDR_ADD_A: slave_address_a_reg <= sfr_wdata;
               `TWS_ADDR_ADD_B: slave_address_b_reg <= sfr_wdata;
               `TWS_ADDR_ADD_C: slave_address_c_reg <= sfr_wdata;
               `TWS_ADDR_ADD_D: slave_address_d_reg <= sfr_wdata;
               default: ;
            endcase
         end
         if (con_wr) begin
            master_select_reg <= sfr_wdata[`TWS_BIT_MSEL];
            if (master_select_reg) begin
               sw_data_out_reg <= sfr_wdata[`TWS_BIT_MDO];
               sw_data_drive_en_reg <= sfr_wdata[`TWS_BIT_MDE];
               sw_clock_out_reg <= sfr_wdata[`TWS_BIT_MCO];
            end else begin
               stop_irq_en_reg <= sfr_wdata[`TWS_BIT_STOPEN];
               iface_soft_reset_reg <= sfr_wdata[`TWS_BIT_SRST];
            end
         end
         // the pin is read back, so a stretching slave delays the sample
         if (master_select_reg & ~sw_data_drive_en_reg & scl_rise) begin
            sw_data_in_reg <= sda_f;
         end
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= S_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         got8_reg <= 1'b0;
         addr_phase_reg <= 1'b0;
         rep_start_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         xfer_direction_reg <= 1'b0;
         byte_done_flag_reg <= 1'b0;
         irq_cause_reg <= `TWS_CAUSE_START;
         accessed_reg <= 1'b0;
         serial_byte_data_reg <= `TWS_RST_DAT;
      end else begin
         if (sfr_wr & (sfr_addr == `TWS_ADDR_DAT)) begin
            serial_byte_data_reg <= sfr_wdata;
         end
         if (byte_set) begin
            byte_done_flag_reg <= 1'b1;
            accessed_reg <= 1'b0;
         end else if (data_access) begin
            byte_done_flag_reg <= 1'b0;
            accessed_reg <= 1'b1;
         end
         if (slave_hold) begin
            state_reg <= S_IDLE;
            sda_low_reg <= 1'b0;
            got8_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            byte_done_flag_reg <= 1'b0;
            accessed_reg <= 1'b0;
         end else if (start_det & (state_reg != S_HALT) &
                      ((state_reg == S_IDLE) | ~xfer_direction_reg)) begin
            state_reg <= S_RXB;
            rep_start_reg <= (state_reg != S_IDLE);
            addr_phase_reg <= 1'b1;
            bit_cnt_reg <= 3'h0;
            got8_reg <= 1'b0;
            sda_low_reg <= 1'b0;
         end else if (stop_det & (state_reg != S_HALT)) begin
            if (state_reg != S_IDLE) begin
               irq_cause_reg <= `TWS_CAUSE_STOP;
            end
            state_reg <= S_IDLE;
            sda_low_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
         end else if (halt_now) begin
            state_reg <= S_HALT;
            sda_low_reg <= 1'b0;
         end else begin
            case (state_reg)
               S_IDLE: ;
               S_RXB: begin
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_f};
                     bit_cnt_reg <= bit_cnt_reg + 3'h1;
                     if (bit_cnt_reg == 3'h7) begin
                        got8_reg <= 1'b1;
                     end
                  end else if (scl_fall & got8_reg) begin
                     got8_reg <= 1'b0;
                     if (~addr_phase_reg | any_hit) begin
                        state_reg <= S_ACK;
                        sda_low_reg <= 1'b1;
                     end else begin
                        state_reg <= S_IDLE;
                        addr_phase_reg <= 1'b0;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     sda_low_reg <= 1'b0;
                     state_reg <= S_STR;
                     serial_byte_data_reg <= shift_reg;
                     addr_phase_reg <= 1'b0;
                     if (addr_phase_reg) begin
                        xfer_direction_reg <= shift_reg[0];
                        irq_cause_reg <= rep_start_reg ?
                           `TWS_CAUSE_RSTART : `TWS_CAUSE_START;
                     end else begin
                        irq_cause_reg <= `TWS_CAUSE_DATA;
                     end
                  end
               end
               S_STR: begin
                  if (~byte_done_flag_reg) begin
                     bit_cnt_reg <= 3'h0;
                     if (xfer_direction_reg) begin
                        state_reg <= S_TXB;
                        shift_reg <= serial_byte_data_reg;
                        sda_low_reg <= ~serial_byte_data_reg[7];
                     end else begin
                        state_reg <= S_RXB;
                     end
                  end
               end
               S_TXB: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= bit_cnt_reg + 3'h1;
                     if (bit_cnt_reg == 3'h7) begin
                        sda_low_reg <= 1'b0;
                        got8_reg <= 1'b0;
                        state_reg <= S_TACK;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_low_reg <= ~shift_reg[6];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     got8_reg <= ~sda_f;
                  end else if (scl_fall) begin
                     got8_reg <= 1'b0;
                     if (got8_reg) begin
                        state_reg <= S_STR;
                        irq_cause_reg <= `TWS_CAUSE_DATA;
                     end else begin
                        state_reg <= S_IDLE;
                     end
                  end
               end
               S_HALT: ;
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   // registered pins, bus read data and interrupt
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         serial_data_pin_out <= 1'b0;
         serial_data_pin_oe <= 1'b0;
         serial_clock_pin_out <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
         sfr_rdata <= 8'h00;
         irq_req <= 1'b0;
         irq_vector <= `TWS_IRQ_VECTOR;
      end else begin
         if (~iface_en) begin
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
         end else if (master_select_reg) begin
            serial_data_pin_out <= sw_data_out_reg;
            serial_data_pin_oe <= sw_data_drive_en_reg;
            serial_clock_pin_out <= sw_clock_out_reg;
            serial_clock_pin_oe <= 1'b1;
         end else begin
            // slave only ever pulls low; the line's pull-up gives high
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= sda_low_reg;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe <= (state_reg == S_STR) &
                                   byte_done_flag_reg;
         end
         // the flag leaves on the access, so the request drops with it
         irq_req <= byte_done_flag_reg & ~data_access &
                    irq_enable_prio2 & global_irq_enable;
         irq_vector <= `TWS_IRQ_VECTOR;
         if (sfr_rd) begin
            case (sfr_addr)
               `TWS_ADDR_ADD_A: sfr_rdata <= slave_address_a_reg;
               `TWS_ADDR_ADD_B: sfr_rdata <= slave_address_b_reg;
               `TWS_ADDR_ADD_C: sfr_rdata <= slave_address_c_reg;
               `TWS_ADDR_ADD_D: sfr_rdata <= slave_address_d_reg;
               `TWS_ADDR_DAT: sfr_rdata <= serial_byte_data_reg;
               `TWS_ADDR_CON: begin
                  if (master_select_reg) begin
                     sfr_rdata <= {sw_data_out_reg, sw_data_drive_en_reg,
                                   sw_clock_out_reg, sw_data_in_reg,
                                   1'b1, 3'h0};
                  end else begin
                     sfr_rdata <= {stop_irq_en_reg, 1'b0, irq_cause_reg,
                                   1'b0, iface_soft_reset_reg,
                                   xfer_direction_reg,
                                   byte_done_flag_reg};
                  end
               end
               default: sfr_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // tws_core

// ==== rtl/tws_defines.vh ====
// constants for the two-wire slave and software master block
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

`define TWS_ADDR_CON 8'hE8
`define TWS_ADDR_ADD_B 8'h91
`define TWS_ADDR_ADD_C 8'h92
`define TWS_ADDR_ADD_D 8'h93
`define TWS_ADDR_DAT 8'h9A
`define TWS_ADDR_ADD_A 8'h9B

`define TWS_RST_ADD_A 8'h55
`define TWS_RST_ADD_X 8'h7F
`define TWS_RST_DAT 8'h00

`define TWS_BIT_FLAG 0
`define TWS_BIT_DIR 1
`define TWS_BIT_SRST 2
`define TWS_BIT_MSEL 3
`define TWS_BIT_MDI 4
`define TWS_BIT_MCO 5
`define TWS_BIT_MDE 6
`define TWS_BIT_MDO 7
`define TWS_BIT_STOPEN 7

`define TWS_CAUSE_START 2'h0
`define TWS_CAUSE_RSTART 2'h1
`define TWS_CAUSE_DATA 2'h2
`define TWS_CAUSE_STOP 2'h3

`define TWS_IRQ_VECTOR 16'h003B

// 50 ns glitch window over the 8 ns core clock, rounded up
`define TWS_FILT_CYCLES 4'h7

`endif

// ==== testbench/test_tws_core.sv ====
// self-checking bench for the two-wire slave and software master
`timescale 1ns/1ps
module test_tws_core;
   reg core_clk, reset_n, sfr_wr, sfr_rd, spi_enable_bit, spi_relocate;
   reg irq_enable_prio2, global_irq_enable;
   reg [7:0] sfr_addr, sfr_wdata, rv, rx;
   reg ack;
   wire [7:0] sfr_rdata;
   wire [15:0] irq_vector;
   wire irq_req, sda_out, sda_oe, scl_out, scl_oe, m_scl_low, m_sda_low;
   wire sda_line = (sda_oe ? sda_out : 1'b1) && !m_sda_low;
   wire scl_line = (scl_oe ? scl_out : 1'b1) && !m_scl_low;
   integer error_cnt = 0;
   integer checks_done = 0;
   integer i;
   localparam [55:0] A_LIST = 56'hE8_91_92_93_9A_9B_A0;
   localparam [55:0] R_LIST = 56'h00_7F_7F_7F_00_55_00;
   initial core_clk = 1'b0;
   always #4 core_clk = !core_clk;
   // short filter keeps bit periods well clear of the glitch window
   tws_core #(.FILT_CYCLES(4'h2)) u_tws_core (.core_clk(core_clk),
      .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .spi_enable_bit(spi_enable_bit), .spi_relocate(spi_relocate),
      .irq_enable_prio2(irq_enable_prio2), .irq_req(irq_req),
      .global_irq_enable(global_irq_enable), .irq_vector(irq_vector),
      .serial_data_pin_in(sda_line), .serial_data_pin_out(sda_out),
      .serial_data_pin_oe(sda_oe), .serial_clock_pin_in(scl_line),
      .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe));
   tws_bus_master u_tws_bus_master (.scl_line(scl_line),
      .sda_line(sda_line), .scl_low(m_scl_low), .sda_low(m_sda_low));
   task automatic chk(input [15:0] got, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task sfr_write(input [7:0] a, input [7:0] d);
      begin
         @(negedge core_clk);
         sfr_addr = a;
         sfr_wdata = d;
         sfr_wr = 1'b1;
         @(negedge core_clk);
         sfr_wr = 1'b0;
      end
   endtask
   task sfr_read(input [7:0] a, output [7:0] d);
      begin
         @(negedge core_clk);
         sfr_addr = a;
         sfr_rd = 1'b1;
         @(negedge core_clk);
         sfr_rd = 1'b0;
         @(negedge core_clk);
         d = sfr_rdata;
      end
   endtask
   task rchk(input [7:0] a, input [7:0] exp);
      reg [7:0] d;
      begin
         sfr_read(a, d);
         chk(d, exp);
      end
   endtask
   task wait_flag;
      integer n;
      begin
         n = 0;
         rv = 8'h00;
         while (rv[0] !== 1'b1 && n < 2000) begin
            sfr_read(8'hE8, rv);
            n = n + 1;
         end
      end
   endtask
   task end_sim;
      begin
         if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      end_sim;
   end
   initial begin
      {reset_n, sfr_wr, sfr_rd, spi_enable_bit, spi_relocate} = 5'h00;
      {irq_enable_prio2, global_irq_enable} = 2'h0;
      {sfr_addr, sfr_wdata} = 16'h0000;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) reset_n = 1'b1;
      for (i = 0; i < 7; i = i + 1)
         rchk(A_LIST[48-8*i +: 8], R_LIST[48-8*i +: 8]);
      sfr_write(8'h92, 8'h3C);
      rchk(8'h92, 8'h3C);
      u_tws_bus_master.start_c;
      u_tws_bus_master.byte_x(8'h24, 1'b1, rx, ack);
      chk(ack, 16'h1);
      u_tws_bus_master.stop_c;
      fork
         begin
            u_tws_bus_master.start_c;
            u_tws_bus_master.byte_x(8'h78, 1'b1, rx, ack);
            chk(ack, 16'h0);
            u_tws_bus_master.byte_x(8'h11, 1'b1, rx, ack);
            chk(ack, 16'h1);
            u_tws_bus_master.stop_c;
         end
         begin
            wait_flag;
            chk(rv, 16'h01);
            chk(irq_req, 16'h0);
            sfr_read(8'h9A, rv);
            sfr_read(8'h9A, rv);
         end
      join
      sfr_write(8'hE8, 8'h04);
      repeat (3) @(negedge core_clk);
      chk({sda_oe, scl_oe}, 16'h0);
      sfr_write(8'hE8, 8'h00);
      {irq_enable_prio2, global_irq_enable} = 2'h3;
      fork
         begin
            u_tws_bus_master.start_c;
            u_tws_bus_master.byte_x(8'h78, 1'b1, rx, ack);
            chk(ack, 16'h0);
            u_tws_bus_master.byte_x(8'h96, 1'b1, rx, ack);
            chk(ack, 16'h0);
            u_tws_bus_master.stop_c;
         end
         begin
            wait_flag;
            chk(rv, 16'h01);
            chk(irq_req, 16'h1);
            chk(irq_vector, 16'h003B);
            rchk(8'h9A, 8'h78);
            chk(irq_req, 16'h0);
            wait_flag;
            chk(rv, 16'h21);
            rchk(8'h9A, 8'h96);
         end
      join
      repeat (20) @(negedge core_clk);
      rchk(8'hE8, 8'h30);
      fork
         begin
            u_tws_bus_master.start_c;
            u_tws_bus_master.byte_x(8'hAA, 1'b1, rx, ack);
            u_tws_bus_master.start_c;
            u_tws_bus_master.byte_x(8'hAB, 1'b1, rx, ack);
            chk(ack, 16'h0);
            u_tws_bus_master.byte_x(8'hFF, 1'b1, rx, ack);
            chk(rx, 16'hA5);
            u_tws_bus_master.stop_c;
         end
         begin
            wait_flag;
            rchk(8'h9A, 8'hAA);
            wait_flag;
            chk(rv, 16'h13);
            sfr_write(8'h9A, 8'hA5);
         end
      join
      sfr_write(8'hE8, 8'h08);
      sfr_write(8'hE8, 8'hE8);
      repeat (2) @(negedge core_clk);
      chk({sda_oe, sda_out, scl_oe, scl_out}, 16'hF);
      sfr_write(8'hE8, 8'h48);
      repeat (2) @(negedge core_clk);
      chk({sda_oe, sda_out, scl_oe, scl_out}, 16'hA);
      for (i = 0; i < 2; i = i + 1) begin
         sfr_write(8'hE8, 8'h08);
         u_tws_bus_master.sda_low = !i[0];
         repeat (10) @(negedge core_clk);
         sfr_write(8'hE8, 8'h28);
         repeat (10) @(negedge core_clk);
         rchk(8'hE8, {3'h1, i[0], 4'h8});
      end
      spi_enable_bit = 1'b1;
      repeat (5) @(negedge core_clk);
      chk({sda_oe, scl_oe}, 16'h0);
      spi_relocate = 1'b1;
      repeat (5) @(negedge core_clk);
      chk(scl_oe, 16'h1);
      sfr_write(8'hE8, 8'h00);
      end_sim;
   end
endmodule // test_tws_core

// ==== testbench/tws_bus_master.sv ====
// behavioural external bus master, open-drain on both lines
`timescale 1ns/1ps
module tws_bus_master (
   input wire scl_line,
   input wire sda_line,
   output reg scl_low,
   output reg sda_low
);
   localparam real QTR = 31.25;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // slave may stretch; bounded so a stuck line cannot hang the run
   task wait_scl;
      integer n;
      begin
         n = 0;
         while (!scl_line && n < 20000) begin
            #1;
            n = n + 1;
         end
      end
   endtask
   task bit_x(input b, output r);
      begin
         #QTR sda_low = !b;
         #QTR scl_low = 1'b0;
         wait_scl;
         #QTR r = sda_line;
         #QTR scl_low = 1'b1;
      end
   endtask
   // also serves as repeated start from a held-low clock
   task start_c;
      begin
         #QTR sda_low = 1'b0;
         #QTR scl_low = 1'b0;
         wait_scl;
         #QTR sda_low = 1'b1;
         #QTR scl_low = 1'b1;
      end
   endtask
   task stop_c;
      begin
         #QTR sda_low = 1'b1;
         #QTR scl_low = 1'b0;
         wait_scl;
         #QTR sda_low = 1'b0;
         #QTR;
      end
   endtask
   task byte_x(input [7:0] tx, input mack, output [7:0] rx,
      output sack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_x(tx[i], rx[i]);
         bit_x(mack, sack);
      end
   endtask
endmodule // tws_bus_master

// ==== testbench/tws_core_properties.sv ====
// assertion checker watching the two-wire block ports
`timescale 1ns/1ps
module tws_core_properties (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   input wire spi_enable_bit,
   input wire spi_relocate,
   input wire irq_enable_prio2,
   input wire global_irq_enable,
   input wire irq_req,
   input wire [15:0] irq_vector,
   input wire serial_data_pin_out,
   input wire serial_data_pin_oe,
   input wire serial_clock_pin_out,
   input wire serial_clock_pin_oe
);
   // master pin bits only land while the mode bit was already set
   reg [3:0] mst_reg;
   reg [4:0] prev_reg;
   wire con_wr = sfr_wr && (sfr_addr == 8'hE8);
   wire ok = !spi_enable_bit || spi_relocate;
   wire mst_on = mst_reg[3] && prev_reg[3] && ok && prev_reg[4];
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mst_reg <= 4'h0;
         prev_reg <= 5'h00;
      end else begin
         prev_reg <= {ok, mst_reg};
         if (con_wr)
            mst_reg <= {sfr_wdata[3],
               mst_reg[3] ? sfr_wdata[7:5] : mst_reg[2:0]};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   vector_fixed_a: assert property (irq_vector == 16'h003B)
      else $error("interrupt vector changed");
   irq_gate_a: assert property (
      irq_req |-> $past(global_irq_enable) && $past(irq_enable_prio2))
      else $error("interrupt without both enables");
   data_clear_a: assert property (
      (sfr_rd || sfr_wr) && sfr_addr == 8'h9A |=> !irq_req)
      else $error("data access left interrupt pending");
   master_clock_a: assert property (mst_on |->
      serial_clock_pin_oe && serial_clock_pin_out == prev_reg[0])
      else $error("master clock pin not following its bit");
   master_data_a: assert property (mst_on |->
      serial_data_pin_oe == prev_reg[1] &&
      (!serial_data_pin_oe || serial_data_pin_out == prev_reg[2]))
      else $error("master data pin not following its bits");
   soft_reset_a: assert property (
      con_wr && sfr_wdata[2] && !sfr_wdata[3] && !mst_reg[3] |->
      ##3 (!serial_data_pin_oe && !serial_clock_pin_oe)[*3])
      else $error("soft reset left a pin driven");
   clock_stretch_a: assert property (
      irq_req && $past(irq_req) && !mst_reg[3] && ok |->
      serial_clock_pin_oe && !serial_clock_pin_out)
      else $error("clock not held while byte pending");
   slave_drive_a: assert property (
      !mst_reg[3] && !prev_reg[3] |->
      !serial_data_pin_out && !serial_clock_pin_out)
      else $error("slave mode drove a pin high");
   cover property (irq_req);
   cover property (mst_on && serial_data_pin_oe);
   cover property (con_wr && sfr_wdata[2]);
endmodule // tws_core_properties
bind tws_core tws_core_properties u_tws_core_properties (
   .core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
   .spi_enable_bit(spi_enable_bit), .spi_relocate(spi_relocate),
   .irq_enable_prio2(irq_enable_prio2),
   .global_irq_enable(global_irq_enable), .irq_req(irq_req),
   .irq_vector(irq_vector), .serial_data_pin_out(serial_data_pin_out),
   .serial_data_pin_oe(serial_data_pin_oe),
   .serial_clock_pin_out(serial_clock_pin_out),
   .serial_clock_pin_oe(serial_clock_pin_oe));
